// file: design/sacc_params.svh
`ifndef SACC_PARAMS_SVH
`define SACC_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SACC_CLK_NS 50
`define SACC_CONV_NS 650
`define SACC_CONV_CYC (`SACC_CONV_NS / `SACC_CLK_NS)
`define SACC_START_NS 20
`define SACC_START_CYC \
	(((`SACC_START_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS) < 1 ? 1 : \
	((`SACC_START_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS))
`define SACC_ACQ_NS 320
`define SACC_ACQ_CYC ((`SACC_ACQ_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS)
// ----------------------------------------
// data layout
// ----------------------------------------
`define SACC_DW 16
`define SACC_RESULT_RST 16'h0000
`define SACC_BYTE_W 8
`define SACC_FILL_ONE 1'b1
`define SACC_CNT_W 5
`define SACC_SAMPLE_W 16
`endif

// file: design/sacc_pkg.sv
package sacc_pkg;
	typedef enum logic [1:0] {SACC_SAMPLE, SACC_CONVERT, SACC_DONE} sacc_dev_st_t;
	typedef enum logic [2:0] {SACC_H_IDLE, SACC_H_LOW, SACC_H_BUSY, SACC_H_READ,
		SACC_H_READ2, SACC_H_ACQ} sacc_host_st_t;
endpackage : sacc_pkg

// file: design/sacc_if.sv
`timescale 1ns/1ps
`include "sacc_params.svh"
interface sacc_if;
	logic convertStartN;
	logic selectN;
	logic readN;
	logic byteSel;
	logic busy;
	logic [`SACC_DW-1:0] resultOut;
	logic [`SACC_DW-1:0] resultOe;
	logic [`SACC_DW-1:0] parallel_result_bus;
	genvar gi;
	generate
		for (gi = 0; gi < `SACC_DW; gi++) begin : g_bus
			// released lanes read low
			assign parallel_result_bus[gi] = resultOe[gi] & resultOut[gi];
		end
	endgenerate
	modport dev (input convertStartN, input selectN, input readN,
		input byteSel, output busy, output resultOut, output resultOe);
	modport host (output convertStartN, output selectN, output readN,
		output byteSel, input busy, input parallel_result_bus);
endinterface : sacc_if

// file: design/sacc_device.sv
//Function
// - internal timer ends conversion after 650 ns
// - host holds start low 20 ns, select low
// - start falling edge captures the input
// - busy high through conversion, then low
// - sampling restarts at busy fall if select low, or at select fall
// - select low only needed at start edge
// - bus driven only when select, read low
// - host waits 320 ns acquisition before start
// - byte low gives full word in order
// - byte high: low byte up, ones below
// - start fall with select low, or select fall, mid-conversion resets
// - reset clears latches, drops busy, samples
`timescale 1ns/1ps
`include "sacc_params.svh"
module sacc_device (
	input wire logic clk_sys,
	input wire logic nrst,
	sacc_if.dev link,
	input wire logic [`SACC_SAMPLE_W-1:0] analogSample,
	output logic sampling
);
	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	logic startPrev_ff;
	logic selPrev_ff;
	logic startFall;
	logic selFall;
	logic selLow;
	assign selLow = ~link.selectN;
	assign startFall = startPrev_ff & ~link.convertStartN;
	assign selFall = selPrev_ff & ~link.selectN;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			startPrev_ff <= 1'b1;
		end else begin
			startPrev_ff <= link.convertStartN;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			selPrev_ff <= 1'b1;
		end else begin
			selPrev_ff <= link.selectN;
		end
	end

	// ----------------------------------------
	// event decode
	// ----------------------------------------
	sacc_pkg::sacc_dev_st_t st_ff;
	sacc_pkg::sacc_dev_st_t nxt_st;
	logic [`SACC_CNT_W-1:0] cnt_ff;
	logic [`SACC_CNT_W-1:0] nxt_cnt;
	logic converting;
	logic takeHit;
	logic abortHit;
	logic doneHit;
	assign converting = (st_ff == sacc_pkg::SACC_CONVERT);
	assign takeHit = ~converting & startFall & selLow;
	assign abortHit = converting & ((startFall & selLow) | selFall);
	assign doneHit = converting & ~abortHit &
		(cnt_ff == `SACC_CNT_W'(`SACC_CONV_CYC - 1));

	// ----------------------------------------
	// state sequencing
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			sacc_pkg::SACC_SAMPLE: begin
				if (takeHit) begin
					nxt_st = sacc_pkg::SACC_CONVERT;
				end
			end
			sacc_pkg::SACC_CONVERT: begin
				if (abortHit || doneHit) begin
					nxt_st = sacc_pkg::SACC_SAMPLE;
				end
			end
			default: begin
				nxt_st = sacc_pkg::SACC_SAMPLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_ff <= sacc_pkg::SACC_SAMPLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// conversion timer
	// ----------------------------------------
	always_comb begin
		nxt_cnt = cnt_ff;
		if (takeHit) begin
			nxt_cnt = '0;
		end else if (converting && !abortHit && !doneHit) begin
			nxt_cnt = cnt_ff + `SACC_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// ----------------------------------------
	// sample hold and result latch
	// ----------------------------------------
	logic [`SACC_DW-1:0] held_ff;
	logic [`SACC_DW-1:0] result_ff;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			held_ff <= `SACC_RESULT_RST;
		end else if (takeHit) begin
			held_ff <= analogSample;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			result_ff <= `SACC_RESULT_RST;
		end else if (abortHit) begin
			result_ff <= `SACC_RESULT_RST;
		end else if (doneHit) begin
			result_ff <= held_ff;
		end
	end

	// ----------------------------------------
	// busy and sampling flags
	// ----------------------------------------
	logic busy_ff;
	logic sampling_ff;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			busy_ff <= 1'b0;
		end else if (takeHit) begin
			busy_ff <= 1'b1;
		end else if (abortHit || doneHit) begin
			busy_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sampling_ff <= 1'b1;
		end else if (takeHit) begin
			sampling_ff <= 1'b0;
		end else if (abortHit) begin
			sampling_ff <= 1'b1;
		end else if (doneHit) begin
			sampling_ff <= selLow;
		end else if (!converting && selFall) begin
			sampling_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// output lanes
	// ----------------------------------------
	logic readHit;
	logic [`SACC_DW-1:0] nxt_out;
	logic [`SACC_DW-1:0] out_ff;
	logic [`SACC_DW-1:0] oe_ff;
	assign readHit = selLow & ~link.readN;
	genvar bi;
	generate
		for (bi = 0; bi < `SACC_DW; bi++) begin : g_lane
			if (bi >= `SACC_BYTE_W) begin : g_hi
				// with byte high, upper lane carries the low byte up; byte low, its own bit
				assign nxt_out[bi] = link.byteSel ?
					result_ff[bi - `SACC_BYTE_W] : result_ff[bi];
			end else begin : g_lo
				assign nxt_out[bi] = link.byteSel ?
					`SACC_FILL_ONE : result_ff[bi];
			end

			always_ff @(posedge clk_sys) begin
				if (!nrst) begin
					out_ff[bi] <= 1'b0;
				end else begin
					out_ff[bi] <= nxt_out[bi];
				end
			end

			always_ff @(posedge clk_sys) begin
				if (!nrst) begin
					oe_ff[bi] <= 1'b0;
				end else begin
					oe_ff[bi] <= readHit;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// link outputs
	// ----------------------------------------
	assign link.resultOut = out_ff;
	assign link.resultOe = oe_ff;
	assign link.busy = busy_ff;
	assign sampling = sampling_ff;
endmodule : sacc_device

// file: design/sacc_host.sv
`timescale 1ns/1ps
`include "sacc_params.svh"
module sacc_host (
	input wire logic clk_sys,
	input wire logic nrst,
	sacc_if.host link,
	input wire logic startReq,
	input wire logic byteMode,
	output logic idle,
	output logic [`SACC_DW-1:0] result,
	output logic resultValid
);
	sacc_pkg::sacc_host_st_t st_ff;
	logic [`SACC_CNT_W-1:0] cnt_ff;
	logic startN_ff;
	logic selN_ff;
	logic readN_ff;
	logic byte_ff;
	logic mode_ff;
	logic [`SACC_DW-1:0] result_ff;
	logic valid_ff;
	logic idle_ff;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_ff <= sacc_pkg::SACC_H_IDLE;
			cnt_ff <= '0;
			startN_ff <= 1'b1;
			selN_ff <= 1'b1;
			readN_ff <= 1'b1;
			byte_ff <= 1'b0;
			mode_ff <= 1'b0;
			result_ff <= '0;
			valid_ff <= 1'b0;
			idle_ff <= 1'b1;
		end else begin
			valid_ff <= 1'b0;
			case (st_ff)
				sacc_pkg::SACC_H_IDLE: begin
					if (startReq) begin
						selN_ff <= 1'b0;
						startN_ff <= 1'b0;
						mode_ff <= byteMode;
						idle_ff <= 1'b0;
						cnt_ff <= '0;
						st_ff <= sacc_pkg::SACC_H_LOW;
					end
				end
				sacc_pkg::SACC_H_LOW: begin
					if (cnt_ff == `SACC_CNT_W'(`SACC_START_CYC - 1)) begin
						startN_ff <= 1'b1;
						st_ff <= sacc_pkg::SACC_H_BUSY;
					end else begin
						cnt_ff <= cnt_ff + `SACC_CNT_W'(1);
					end
				end
				sacc_pkg::SACC_H_BUSY: begin
					if (!link.busy) begin
						readN_ff <= 1'b0;
						byte_ff <= 1'b0;
						st_ff <= sacc_pkg::SACC_H_READ;
					end
				end
				sacc_pkg::SACC_H_READ: begin
					if (!readN_ff && cnt_ff == `SACC_CNT_W'(0)) begin
						cnt_ff <= `SACC_CNT_W'(1);
					end else if (mode_ff) begin
						result_ff[`SACC_DW-1:`SACC_BYTE_W] <=
							link.parallel_result_bus[`SACC_DW-1:`SACC_BYTE_W];
						byte_ff <= 1'b1;
						cnt_ff <= '0;
						st_ff <= sacc_pkg::SACC_H_READ2;
					end else begin
						result_ff <= link.parallel_result_bus;
						valid_ff <= 1'b1;
						readN_ff <= 1'b1;
						cnt_ff <= '0;
						st_ff <= sacc_pkg::SACC_H_ACQ;
					end
				end
				sacc_pkg::SACC_H_READ2: begin
					if (cnt_ff == `SACC_CNT_W'(0)) begin
						cnt_ff <= `SACC_CNT_W'(1);
					end else begin
						result_ff[`SACC_BYTE_W-1:0] <=
							link.parallel_result_bus[`SACC_DW-1:`SACC_BYTE_W];
						valid_ff <= 1'b1;
						readN_ff <= 1'b1;
						byte_ff <= 1'b0;
						cnt_ff <= '0;
						st_ff <= sacc_pkg::SACC_H_ACQ;
					end
				end
				sacc_pkg::SACC_H_ACQ: begin
					if (cnt_ff == `SACC_CNT_W'(`SACC_ACQ_CYC - 1)) begin
						idle_ff <= 1'b1;
						cnt_ff <= '0;
						st_ff <= sacc_pkg::SACC_H_IDLE;
					end else begin
						cnt_ff <= cnt_ff + `SACC_CNT_W'(1);
					end
				end
				default: begin
					st_ff <= sacc_pkg::SACC_H_IDLE;
				end
			endcase
		end
	end
	assign link.convertStartN = startN_ff;
	assign link.selectN = selN_ff;
	assign link.readN = readN_ff;
	assign link.byteSel = byte_ff;
	assign result = result_ff;
	assign resultValid = valid_ff;
	assign idle = idle_ff;
endmodule : sacc_host

// file: bench/sacc_properties.sv
`timescale 1ns/1ps
`include "sacc_params.svh"
module sacc_properties (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic convertStartN,
	input wire logic selectN,
	input wire logic readN,
	input wire logic byteSel,
	input wire logic busy,
	input wire logic [`SACC_DW-1:0] resultOut,
	input wire logic [`SACC_DW-1:0] resultOe
);
	// ------
	// checks
	// ------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	sequence s_take;
		$fell(convertStartN) && !selectN && !busy;
	endsequence
	sequence s_conv;
		busy ##12 busy ##1 !busy;
	endsequence
	AST_TAKE: assert property (s_take |=> busy)
		else $error("busy did not rise");
	AST_CONV: assert property ($rose(busy) |-> s_conv)
		else $error("conversion length wrong");
	AST_CAUSE: assert property ($rose(busy) |-> !$past(convertStartN))
		else $error("busy rose without start");
	AST_OE_OFF: assert property (|resultOe |-> !$past(selectN) && !$past(readN))
		else $error("bus driven while not read");
	AST_OE_ON: assert property (!selectN && !readN |=> &resultOe)
		else $error("bus not driven on read");
	AST_FOLD: assert property (|resultOe && $past(byteSel)
		|-> resultOut[7:0] == 8'hff)
		else $error("lower byte not all ones");
	AST_ACQ: assert property ($fell(busy) |=> convertStartN[*7])
		else $error("acquisition too short");
	AST_START: assert property ($fell(convertStartN)
		|-> !selectN ##[1:2] convertStartN)
		else $error("start strobe misformed");
	AST_READ: assert property ($fell(readN) |-> !busy && !selectN)
		else $error("read during conversion");
endmodule : sacc_properties

// file: bench/sar_adc_conversion_control_tb.sv
`timescale 1ns/1ps
`include "sacc_params.svh"
module sar_adc_conversion_control_tb;
	typedef struct {logic byteMode; logic [15:0] sample;} sacc_row_t;
	sacc_row_t rows[4] = '{'{1'b0, 16'h8001}, '{1'b1, 16'h7ffe},
		'{1'b0, 16'hffff}, '{1'b1, 16'h0000}};
	logic clk_sys = 0;
	logic nrst = 0;
	logic startReq = 0;
	logic byteMode = 0;
	logic [15:0] sample = 16'h0000;
	logic [15:0] result;
	logic idle, resultValid, sampling2;
	int miscompares = 0;
	int check_count = 0;
	sacc_if link();
	sacc_if link2();
	always #25 clk_sys = ~clk_sys;
	sacc_device u_sacc_device(.clk_sys(clk_sys), .nrst(nrst), .link(link),
		.analogSample(sample), .sampling());
	sacc_host u_sacc_host(.clk_sys(clk_sys), .nrst(nrst), .link(link),
		.startReq(startReq), .byteMode(byteMode), .idle(idle),
		.result(result), .resultValid(resultValid));
	sacc_device u_sacc_device_2(.clk_sys(clk_sys), .nrst(nrst),
		.link(link2), .analogSample(16'h5a5a), .sampling(sampling2));
	sacc_properties u_sacc_properties(.clk_sys(clk_sys), .nrst(nrst),
		.convertStartN(link.convertStartN), .selectN(link.selectN),
		.readN(link.readN), .byteSel(link.byteSel), .busy(link.busy),
		.resultOut(link.resultOut), .resultOe(link.resultOe));
	// ------
	// tasks
	// ------
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic pick(input int s);
		return s == 0 ? idle : s == 1 ? resultValid : link2.busy;
	endfunction : pick
	task automatic waitFor(input int s, input logic lvl);
		int n;
		n = 0;
		while (pick(s) !== lvl) begin
			@(negedge clk_sys);
			n++;
			if (n > 100) begin
				miscompares++;
				print_verdict();
			end
		end
	endtask : waitFor
	// ------
	// sequence
	// ------
	initial begin
		link2.convertStartN = 1;
		link2.selectN = 1;
		link2.readN = 1;
		link2.byteSel = 0;
		repeat (5) @(negedge clk_sys);
		check(link2.resultOe, 16'h0000);
		check(16'(link.busy), 16'h0000);
		nrst = 1;
		foreach (rows[i]) begin
			waitFor(0, 1);
			byteMode = rows[i].byteMode;
			sample = rows[i].sample;
			startReq = 1;
			@(negedge clk_sys);
			startReq = 0;
			repeat (3) @(negedge clk_sys);
			sample = ~rows[i].sample;
			waitFor(1, 1);
			check(result, rows[i].sample);
		end
		link2.selectN = 0;
		link2.convertStartN = 0;
		@(negedge clk_sys);
		link2.convertStartN = 1;
		@(negedge clk_sys);
		check(16'(link2.busy), 16'h0001);
		waitFor(2, 0);
		link2.readN = 0;
		link2.byteSel = 1;
		repeat (2) @(negedge clk_sys);
		check(link2.parallel_result_bus, 16'h5aff);
		link2.byteSel = 0;
		repeat (2) @(negedge clk_sys);
		check(link2.parallel_result_bus, 16'h5a5a);
		repeat (7) @(negedge clk_sys);
		link2.convertStartN = 0;
		@(negedge clk_sys);
		link2.convertStartN = 1;
		repeat (3) @(negedge clk_sys);
		link2.convertStartN = 0;
		repeat (3) @(negedge clk_sys);
		check(16'(link2.busy), 16'h0000);
		check(16'(sampling2), 16'h0001);
		check(link2.parallel_result_bus, 16'h0000);
		check(link2.resultOe, 16'hffff);
		link2.readN = 1;
		link2.convertStartN = 1;
		repeat (2) @(negedge clk_sys);
		check(link2.resultOe, 16'h0000);
		check(link2.parallel_result_bus, 16'h0000);
		link2.convertStartN = 0;
		@(negedge clk_sys);
		link2.convertStartN = 1;
		link2.selectN = 1;
		waitFor(2, 0);
		check(16'(sampling2), 16'h0000);
		link2.selectN = 0;
		repeat (2) @(negedge clk_sys);
		check(16'(sampling2), 16'h0001);
		link2.convertStartN = 0;
		@(negedge clk_sys);
		link2.convertStartN = 1;
		link2.selectN = 1;
		check(16'(link2.busy), 16'h0001);
		repeat (3) @(negedge clk_sys);
		link2.selectN = 0;
		repeat (2) @(negedge clk_sys);
		check(16'(link2.busy), 16'h0000);
		check(16'(sampling2), 16'h0001);
		print_verdict();
	end
endmodule : sar_adc_conversion_control_tb
